/* File: core/ssc_config.sv */
// Overview of operation
// - direction field selects off, out, in, auto
// - bit 5 picks falling or rising edge
// - undefined writes rejected, invalid flag raised
// - auto decides direction once at enable
// - high or fast pin picks input
// - follower always input; sync fault raised when no fast sync edges
// - in to out at floor keeps floor
// - leader in fault: oscillator at 70 percent
// - upper byte, leader index read zero
// - last index codes zero to three valid
// - stack register read-only while converting
// - stand-alone at power-up keeps back-channel off
// - later stack writes wait for power-up
// - activated back-channel allows live resizing
// - misc register word access, immediate effect
// - override bit picks stored or strap
module ssc_config
	import ssc_pkg::*;
#(
	parameter int PERIOD_CYCLES = 20
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire ssc_pkg::ssc_cmd_type i_cmd,
	input wire logic i_store,
	input wire logic i_power_up,
	input wire logic i_pin_override,
	input wire logic [3:0] i_strap_last_index,
	input wire logic i_enable_cond,
	input wire logic i_sync_pin,
	input wire logic i_follower,
	output ssc_pkg::ssc_rsp_type o_rsp,
	output logic o_sync_out_en,
	output logic o_sync_in_en,
	output logic o_sync_rising,
	output logic o_converting,
	output logic o_sync_fault,
	output logic [6:0] o_freq_pct,
	output logic o_backchannel_en,
	output logic [3:0] o_stack_last_index,
	output logic [15:0] o_misc
);
	import ssc_pkg::*;

	logic [7:0] sync_reg;
	logic [3:0] last_index;
	logic [15:0] misc_reg;
	logic bc_active;
	logic run;
	logic dir_in;
	logic dir_out;
	logic at_floor;
	logic edge_hit;
	logic fast;
	logic [15:0] nv_stack;
	logic [7:0] nv_sync;
	logic [15:0] nv_misc;
	ssc_dir_type dir;

	assign dir = ssc_dir_type'(sync_reg[SSC_DIR_HI:SSC_DIR_LO]);

	// refuse a switching period the edge timer cannot serve
	if (PERIOD_CYCLES < 4) begin : g_period_check
		$error("switching period too short");
	end

	// ----------------------------------------
	// write validity checks
	// ----------------------------------------
	function automatic logic sync_ok(input logic [15:0] d);
		sync_ok = (d[4:0] == SSC_SYNC_LOW_FIXED) && (d[15:8] == 8'h_00);
	endfunction

	function automatic logic stack_ok(input logic [15:0] d);
		stack_ok = (d[15:4] == 12'h_000) && (d[3:0] <= SSC_LAST_MAX);
	endfunction

	// stack register image: only the last index is stored
	function automatic logic [15:0] stack_word(input logic [3:0] last);
		stack_word = {8'h_00, SSC_LEADER_INDEX, last};
	endfunction

	// ----------------------------------------
	// read decode
	// ----------------------------------------
	function automatic logic [15:0] read_value(input logic [7:0] code);
		if (code == SSC_CMD_SYNC) begin
			read_value = {8'h_00, sync_reg};
		end else if (code == SSC_CMD_STACK) begin
			read_value = stack_word(last_index);
		end else if (code == SSC_CMD_MISC) begin
			read_value = misc_reg;
		end else begin
			read_value = 16'h_0000;
		end
	endfunction

	logic wr_sync;
	logic wr_stack;
	logic wr_misc;
	logic bad_wr;

	assign wr_sync = i_cmd.wr && i_cmd.code == SSC_CMD_SYNC && !i_cmd.word &&
		sync_ok(i_cmd.data);
	assign wr_stack = i_cmd.wr && i_cmd.code == SSC_CMD_STACK && i_cmd.word &&
		!run && stack_ok(i_cmd.data);
	assign wr_misc = i_cmd.wr && i_cmd.code == SSC_CMD_MISC && i_cmd.word;
	assign bad_wr = i_cmd.wr && !wr_sync && !wr_stack && !wr_misc;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// edge timer for the sync pin
	ssc_edge_rate #(
		.PERIOD_CYCLES(PERIOD_CYCLES)
	) u_rate (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_sync_pin(i_sync_pin),
		.i_rising(sync_reg[SSC_EDGE_BIT]),
		.o_edge(edge_hit),
		.o_fast(fast)
	);

	// stored image mirrors the readable register
	ssc_nvm_store u_nvm (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_store(i_store),
		.i_stack(stack_word(last_index)),
		.i_sync(sync_reg),
		.i_misc(misc_reg),
		.o_stack(nv_stack),
		.o_sync(nv_sync),
		.o_misc(nv_misc)
	);

	// ----------------------------------------
	// sync settings register
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sync_reg <= SSC_SYNC_RESET;
		end else if (i_power_up) begin
			sync_reg <= nv_sync;
		end else if (wr_sync) begin
			sync_reg <= i_cmd.data[7:0];
		end
	end

	// ----------------------------------------
	// stack settings and back-channel
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			last_index <= 4'h_0;
			bc_active <= 1'b0;
		end else if (i_power_up) begin
			if (i_pin_override) begin
				last_index <= i_strap_last_index;
				bc_active <= i_strap_last_index != 4'h_0;
			end else begin
				last_index <= nv_stack[3:0];
				bc_active <= nv_stack[3:0] != 4'h_0;
			end
		end else if (wr_stack) begin
			// a size written while the back-channel is off is kept
			// for storing, but only counts after the next power-up
			// activation only at power-up
			last_index <= i_cmd.data[3:0];
		end
	end

	// misc settings, immediate
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			misc_reg <= SSC_MISC_RESET;
		end else if (i_power_up) begin
			misc_reg <= nv_misc;
		end else if (wr_misc) begin
			misc_reg <= i_cmd.data;
		end
	end

	// ----------------------------------------
	// run state and direction resolution
	// ----------------------------------------
	// registered enable; low in the first enabled cycle
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			run <= 1'b0;
		end else begin
			run <= i_enable_cond;
		end
	end

	// direction; in auto mode the old choice stands while disabled
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			dir_in <= 1'b0;
			dir_out <= 1'b0;
		end else if (i_follower) begin
			dir_in <= 1'b1;
			dir_out <= 1'b0;
		end else if (dir == SSC_DIR_AUTO) begin
			if (i_enable_cond && !run) begin
				dir_in <= i_sync_pin || fast;
				dir_out <= !(i_sync_pin || fast);
			end
		end else begin
			dir_in <= dir == SSC_DIR_IN;
			dir_out <= dir == SSC_DIR_OUT;
		end
	end

	// ----------------------------------------
	// sync fault and frequency floor
	// ----------------------------------------
	// judged from the second enabled cycle, once the direction
	// chosen at enable has settled; a stale choice would flag
	// a fault on a device that has just picked sync output
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_sync_fault <= 1'b0;
		end else if (!i_enable_cond) begin
			o_sync_fault <= 1'b0;
		end else if (run && dir_in && !fast) begin
			o_sync_fault <= 1'b1;
		end
	end

	// the floor holds until disable, even if the direction
	// turns to output in the meantime
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			at_floor <= 1'b0;
		end else if (!i_enable_cond) begin
			at_floor <= 1'b0;
		end else if (run && dir_in && (!fast || o_sync_fault)) begin
			at_floor <= 1'b1;
		end
	end

	// ----------------------------------------
	// outputs and bus answer
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_sync_out_en <= 1'b0;
			o_sync_in_en <= 1'b0;
			o_sync_rising <= 1'b0;
			o_converting <= 1'b0;
			o_freq_pct <= SSC_NOMINAL_PCT7;
			o_backchannel_en <= 1'b0;
			o_stack_last_index <= 4'h_0;
			o_misc <= SSC_MISC_RESET;
		end else begin
			o_sync_out_en <= dir_out;
			o_sync_in_en <= dir_in;
			o_sync_rising <= sync_reg[SSC_EDGE_BIT];
			o_converting <= run;
			o_freq_pct <= at_floor ? SSC_FLOOR_PCT7 : SSC_NOMINAL_PCT7;
			o_backchannel_en <= bc_active;
			o_stack_last_index <= bc_active ? last_index : 4'h_0;
			o_misc <= misc_reg;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_rsp <= '0;
		end else begin
			o_rsp.ack <= i_cmd.wr || i_cmd.rd;
			o_rsp.invalid <= bad_wr;
			// reads answer with the register image, else zero
			if (i_cmd.rd) begin
				o_rsp.data <= read_value(i_cmd.code);
			end else begin
				o_rsp.data <= 16'h_0000;
			end
		end
	end
endmodule

/* File: core/ssc_edge_rate.sv */
module ssc_edge_rate
	import ssc_pkg::*;
#(
	parameter int PERIOD_CYCLES = 20
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_sync_pin,
	input wire logic i_rising,
	output logic o_edge,
	output logic o_fast
);
	// refuse a period too short for the edge timer
	if (PERIOD_CYCLES < 4) begin : g_period_check
		$error("period too short");
	end

	// window: an edge must come within period / 0.75
	localparam int LIMIT = (PERIOD_CYCLES * 100) / SSC_DETECT_PCT;
	localparam int CW = $clog2(LIMIT + 2);

	logic prev;
	logic [CW-1:0] gap;

	// --------------------------------
	// edge detection on chosen edge
	// --------------------------------
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			prev <= 1'b0;
		end else begin
			prev <= i_sync_pin;
		end
	end

	assign o_edge = i_rising ? (i_sync_pin & ~prev) : (~i_sync_pin & prev);

	// cycles since last chosen edge, saturating
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			gap <= CW'(LIMIT + 1);
		end else if (o_edge) begin
			gap <= '0;
		end else if (gap <= CW'(LIMIT)) begin
			gap <= gap + CW'(1);
		end
	end

	assign o_fast = (gap <= CW'(LIMIT));
endmodule

/* File: core/ssc_nvm_store.sv */
module ssc_nvm_store
	import ssc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_store,
	input wire logic [15:0] i_stack,
	input wire logic [7:0] i_sync,
	input wire logic [15:0] i_misc,
	output logic [15:0] o_stack,
	output logic [7:0] o_sync,
	output logic [15:0] o_misc
);
	// ----------------------------------------
	// stored copy, cleared to reset values by system reset
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_stack <= SSC_STACK_RESET;
			o_sync <= SSC_SYNC_RESET;
			o_misc <= SSC_MISC_RESET;
		end else if (i_store) begin
			o_stack <= i_stack;
			o_sync <= i_sync;
			o_misc <= i_misc;
		end
	end
endmodule

/* File: core/ssc_pkg.sv */
package ssc_pkg;
	// ----------------------------------------
	// command codes
	// ----------------------------------------
	localparam logic [7:0] SSC_CMD_SYNC = 8'h_e4;
	localparam logic [7:0] SSC_CMD_STACK = 8'h_ec;
	localparam logic [7:0] SSC_CMD_MISC = 8'h_ed;

	// ----------------------------------------
	// field layout and fixed values
	// ----------------------------------------
	localparam int SSC_DIR_HI = 7;
	localparam int SSC_DIR_LO = 6;
	localparam int SSC_EDGE_BIT = 5;
	localparam logic [4:0] SSC_SYNC_LOW_FIXED = 5'h_10;
	localparam logic [7:0] SSC_SYNC_RESET = 8'h_10;
	localparam logic [15:0] SSC_STACK_RESET = 16'h_0000;
	localparam logic [3:0] SSC_LEADER_INDEX = 4'h_0;
	localparam logic [3:0] SSC_LAST_MAX = 4'h_3;
	localparam logic [15:0] SSC_MISC_RESET = 16'h_0000;
	localparam int SSC_OVR_STACK_BIT = 12;

	// ----------------------------------------
	// frequency figures, in percent of nominal
	// ----------------------------------------
	localparam int SSC_DETECT_PCT = 75;
	localparam int SSC_FLOOR_PCT = 70;
	localparam logic [6:0] SSC_FLOOR_PCT7 = 7'(SSC_FLOOR_PCT);
	localparam logic [6:0] SSC_NOMINAL_PCT7 = 7'h_64;

	// sync direction codes
	typedef enum logic [1:0] {
		SSC_DIR_OFF = 2'h_0,
		SSC_DIR_OUT = 2'h_1,
		SSC_DIR_IN = 2'h_2,
		SSC_DIR_AUTO = 2'h_3
	} ssc_dir_type;

	// host command from the serial bus engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic word;
		logic [7:0] code;
		logic [15:0] data;
	} ssc_cmd_type;

	// answer to the serial bus engine
	typedef struct packed {
		logic ack;
		logic invalid;
		logic [15:0] data;
	} ssc_rsp_type;
endpackage

/* File: dv/ssc_config_props.sv */
module ssc_config_props
	import ssc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire ssc_pkg::ssc_cmd_type i_cmd,
	input wire logic i_enable_cond,
	input wire logic i_follower,
	input wire ssc_pkg::ssc_rsp_type o_rsp,
	input wire logic o_sync_out_en,
	input wire logic o_sync_in_en,
	input wire logic o_sync_rising,
	input wire logic o_converting,
	input wire logic o_sync_fault,
	input wire logic [6:0] o_freq_pct,
	input wire logic o_backchannel_en,
	input wire logic [3:0] o_stack_last_index
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// checks
	// ----
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);
	// a request, and a well formed sync byte write
	sequence s_req;
		i_cmd.wr || i_cmd.rd;
	endsequence
	sequence s_sync_ok;
		i_cmd.wr && !i_cmd.word && i_cmd.code == SSC_CMD_SYNC &&
			i_cmd.data == {8'h_00, i_cmd.data[7:5], SSC_SYNC_LOW_FIXED};
	endsequence
	a_req_acked: assert property (s_req |=> o_rsp.ack)
		else $error("ack missing");
	a_idle_quiet: assert property (!(i_cmd.wr || i_cmd.rd) |=> !o_rsp.ack)
		else $error("stray ack");
	a_sync_accepted: assert property (s_sync_ok |=> !o_rsp.invalid)
		else $error("good sync write refused");
	a_edge_applied: assert property (
		s_sync_ok ##1 !i_cmd.wr [*2] |=>
		o_sync_rising == $past(i_cmd.data[5], 3))
		else $error("edge bit not applied");
	a_stack_refused: assert property (
		i_cmd.wr && i_cmd.code == SSC_CMD_STACK && ($past(i_enable_cond) ||
		!i_cmd.word || i_cmd.data > 16'h_0003) |=> o_rsp.invalid)
		else $error("bad stack write accepted");
	a_dir_exclusive: assert property (!(o_sync_out_en && o_sync_in_en))
		else $error("sync in and out together");
	a_freq_legal: assert property (
		o_freq_pct == SSC_NOMINAL_PCT7 || o_freq_pct == SSC_FLOOR_PCT7)
		else $error("odd frequency figure");
	a_bc_idle: assert property (
		!o_backchannel_en |-> o_stack_last_index == 4'h_0)
		else $error("stack size out while back-channel off");
	a_fault_cleared: assert property (
		$fell(i_enable_cond) |-> ##[1:2] !o_sync_fault)
		else $error("fault held after disable");
	a_follower_in: assert property (i_follower [*3] |-> !o_sync_out_en)
		else $error("follower drives sync");
	a_floor_on_fault: assert property (o_sync_fault |=>
		o_freq_pct == SSC_FLOOR_PCT7)
		else $error("fault without frequency floor");
	a_conv_tracks: assert property (
		o_converting == $past(i_enable_cond, 2))
		else $error("converting flag off its enable");
endmodule
bind ssc_config ssc_config_props u_props (
	.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cmd(i_cmd),
	.i_enable_cond(i_enable_cond), .i_follower(i_follower),
	.o_rsp(o_rsp), .o_sync_out_en(o_sync_out_en),
	.o_sync_in_en(o_sync_in_en), .o_sync_rising(o_sync_rising),
	.o_converting(o_converting), .o_sync_fault(o_sync_fault),
	.o_freq_pct(o_freq_pct), .o_backchannel_en(o_backchannel_en),
	.o_stack_last_index(o_stack_last_index)
);

/* File: dv/ssc_sync_peer.sv */
// peer on the sync pin: low idle, held high, or nominal-rate clock
module ssc_sync_peer (
	input wire logic i_clk,
	input wire logic [1:0] i_mode,
	output logic o_sync_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt = 4'h_0;
	logic tog = 1'b0;
	always @(posedge i_clk) begin
		cnt <= (cnt == 4'h_9) ? 4'h_0 : cnt + 4'h_1;
		if (cnt == 4'h_9)
			tog <= ~tog;
	end
	assign o_sync_pin = i_mode[1] ? tog : i_mode[0];
endmodule

/* File: dv/sync_and_stack_config_tb.sv */
module sync_and_stack_config_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ssc_pkg::*;
	logic clk, rst, store, pwr, ovr, en, foll, pin, out_en, in_en;
	logic rising, conv, fault, bc_en;
	logic [1:0] mode;
	logic [3:0] strap, last_idx;
	logic [6:0] freq;
	logic [15:0] misc;
	ssc_cmd_type cmd;
	ssc_rsp_type rsp, r;
	int n_fail = 0;
	int samples_checked = 0;
	ssc_config u_dut (.i_clk(clk), .i_sys_rst(rst), .i_cmd(cmd),
		.i_store(store), .i_power_up(pwr), .i_pin_override(ovr),
		.i_strap_last_index(strap), .i_enable_cond(en), .i_sync_pin(pin),
		.i_follower(foll), .o_rsp(rsp), .o_sync_out_en(out_en),
		.o_sync_in_en(in_en), .o_sync_rising(rising), .o_converting(conv),
		.o_sync_fault(fault), .o_freq_pct(freq), .o_backchannel_en(bc_en),
		.o_stack_last_index(last_idx), .o_misc(misc));
	ssc_sync_peer u_peer (.i_clk(clk), .i_mode(mode), .o_sync_pin(pin));
	// ----
	// tasks
	// ----
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, got);
		samples_checked++;
		if (got !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, got);
		end
	endtask
	// one command pulse, answer taken one cycle later
	task automatic xfer(input logic w, wd, input logic [7:0] c,
		input logic [15:0] d);
		@(negedge clk);
		cmd = '{wr: w, rd: !w, word: wd, code: c, data: d};
		@(negedge clk);
		r = rsp;
		cmd = '0;
		repeat (3) @(negedge clk);
	endtask
	task automatic wr(input logic [7:0] c, input logic wd,
		input logic [15:0] d, input logic inv);
		xfer(1'b1, wd, c, d);
		chk("ack", 16'h_0001, 16'(r.ack));
		chk("invalid", 16'(inv), 16'(r.invalid));
	endtask
	task automatic rd(input logic [7:0] c, input logic wd, input logic [15:0] e);
		xfer(1'b0, wd, c, 16'h_0000);
		chk("read", e, r.data);
	endtask
	task automatic pulse(input logic s, p);
		@(negedge clk);
		store = s;
		pwr = p;
		@(negedge clk);
		store = 1'b0;
		pwr = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	task automatic run(input logic e, input int n);
		en = e;
		repeat (n) @(negedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// watchdog
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		{store, pwr, ovr, en, foll, mode, strap} = '0;
		cmd = '0;
		rst = 1'b1;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		rd(SSC_CMD_SYNC, 1'b0, 16'h_0010);
		for (int i = 0; i < 3; i++) begin
			wr(SSC_CMD_SYNC, 1'b0, {8'h_00, 2'(i), 1'(i), 5'h_10}, 1'b0);
			chk("out_en", 16'(i == 1), 16'(out_en));
			chk("in_en", 16'(i == 2), 16'(in_en));
			chk("rising", 16'(i % 2), 16'(rising));
		end
		wr(SSC_CMD_SYNC, 1'b0, 16'h_0051, 1'b1);
		wr(SSC_CMD_SYNC, 1'b1, 16'h_0050, 1'b1);
		rd(SSC_CMD_SYNC, 1'b0, 16'h_0090);
		wr(SSC_CMD_SYNC, 1'b0, 16'h_00f0, 1'b0);
		run(1'b1, 5);
		chk("auto out", 16'h_0001, 16'(out_en));
		mode = 2'h_1;
		run(1'b1, 5);
		chk("auto held", 16'h_0001, 16'(out_en));
		run(1'b0, 3);
		run(1'b1, 5);
		chk("auto in", 16'h_0001, 16'(in_en));
		run(1'b0, 3);
		mode = 2'h_2;
		run(1'b0, 60);
		run(1'b1, 5);
		chk("auto fast", 16'h_0001, 16'(in_en));
		run(1'b0, 3);
		wr(SSC_CMD_MISC, 1'b1, 16'h_1234, 1'b0);
		chk("misc", 16'h_1234, misc);
		wr(SSC_CMD_MISC, 1'b0, 16'h_00ff, 1'b1);
		rd(SSC_CMD_MISC, 1'b1, 16'h_1234);
		pulse(1'b0, 1'b1);
		chk("bc off", 16'h_0000, 16'(bc_en));
		wr(SSC_CMD_STACK, 1'b1, 16'h_0003, 1'b0);
		chk("bc wait", 16'h_0000, 16'(bc_en));
		wr(SSC_CMD_STACK, 1'b1, 16'h_0004, 1'b1);
		wr(SSC_CMD_STACK, 1'b1, 16'h_0013, 1'b1);
		wr(SSC_CMD_STACK, 1'b0, 16'h_0002, 1'b1);
		rd(SSC_CMD_STACK, 1'b1, 16'h_0003);
		pulse(1'b1, 1'b0);
		pulse(1'b0, 1'b1);
		chk("bc on", 16'h_0001, 16'(bc_en));
		chk("last", 16'h_0003, 16'(last_idx));
		{ovr, strap} = {1'b1, 4'h_2};
		pulse(1'b0, 1'b1);
		chk("strap", 16'h_0002, 16'(last_idx));
		wr(SSC_CMD_STACK, 1'b1, 16'h_0001, 1'b0);
		chk("live", 16'h_0001, 16'(last_idx));
		wr(SSC_CMD_SYNC, 1'b0, 16'h_0050, 1'b0);
		run(1'b1, 5);
		chk("conv", 16'h_0001, 16'(conv));
		wr(SSC_CMD_STACK, 1'b1, 16'h_0002, 1'b1);
		rd(SSC_CMD_STACK, 1'b1, 16'h_0001);
		run(1'b0, 3);
		{foll, mode} = {1'b1, 2'h_0};
		run(1'b1, 80);
		chk("no sync", 16'h_0001, 16'(fault));
		chk("floor", 16'(SSC_FLOOR_PCT7), 16'(freq));
		chk("fol in", 16'h_0000, 16'(out_en));
		run(1'b0, 3);
		chk("cleared", 16'h_0000, 16'(fault));
		mode = 2'h_2;
		run(1'b0, 60);
		run(1'b1, 60);
		chk("locked", 16'h_0000, 16'(fault));
		chk("no floor", 16'(SSC_NOMINAL_PCT7), 16'(freq));
		mode = 2'h_0;
		run(1'b1, 80);
		chk("lost", 16'h_0001, 16'(fault));
		foll = 1'b0;
		run(1'b1, 5);
		chk("leader out", 16'h_0001, 16'(out_en));
		chk("leader floor", 16'(SSC_FLOOR_PCT7), 16'(freq));
		run(1'b0, 3);
		chk("nominal", 16'(SSC_NOMINAL_PCT7), 16'(freq));
		tally_and_finish();
	end
endmodule
